// File: rtl/exc_capability_fields.sv
`timescale 1ns/100ps

// How it works
// RULE1: The port type field is a 4-bit code with only the listed bridge/port codes in use.
// RULE2: Port type reads 7h in forward mode and 8h in reverse mode.
// RULE3: Slot implemented reads 0 in forward mode and 1 in reverse mode.
// RULE4: Phantom functions field reads zero.
// RULE5: The extended tag bit reads one.
// RULE6: The L0s acceptable latency field reads 000.
// RULE7: L0s codes run from under 64 ns through doubling ranges to over 4 us.
// RULE8: The L1 acceptable latency field reads 000.
// RULE9: L1 codes run from under 1 us through doubling ranges to over 64 us.
// RULE10: Attention button present is set only with hot-plug strapped on in forward mode.
// RULE11: Attention and power indicator present follow the same condition.
// RULE12: Each power limit message loads the captured value, which resets to 00h.
// RULE13: Each power limit message loads the captured scale, which resets to 00.
// RULE14: Supported payload size reads the 256-byte code.
// RULE15: Version reads 1h, message number and reserved bits zero, writes ignored.
module exc_capability_fields (
    input wire logic clock,
    input wire logic reset_n,
    input wire exc_pkg::exc_wb_req_s wbReq,
    output exc_pkg::exc_wb_rsp_s wbRsp,
    input wire logic reverseStrap,
    input wire logic hotPlugStrap,
    input wire exc_pkg::exc_pwr_msg_s pwrMsg
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        exc_pkg::exc_bus_state_e busState;
        logic [31:0] rspDat;
        logic rspAck;
        logic [7:0] reqAdr;
        logic strapDone;
        logic reverseMode;
        logic hotPlug;
        logic [7:0] pwrValue;
        logic [1:0] pwrScale;
    } exc_state_s;

    localparam exc_state_s RST_STATE = '{
        busState: exc_pkg::EXC_ST_IDLE,
        rspDat: exc_pkg::RST_RSP_DAT,
        rspAck: 1'b0,
        reqAdr: exc_pkg::RST_ADR,
        strapDone: 1'b0,
        reverseMode: 1'b0,
        hotPlug: 1'b0,
        pwrValue: exc_pkg::RST_PWR_VALUE,
        pwrScale: exc_pkg::RST_PWR_SCALE
    };

    logic rstSyncN;
    exc_state_s state_reg;
    exc_state_s state_next;
    exc_pkg::exc_cap_upper_s capUpper;
    exc_pkg::exc_dev_cap_s devCap;
    logic hotPlugFwd;
    logic reqHit;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    exc_reset_sync u_reset_sync (
        .clock(clock),
        .reset_n(reset_n),
        .rstSyncN(rstSyncN)
    );

    // ----------------------------------------
    // Field assembly
    // ----------------------------------------
    // Indicators exist only for a forward bridge with hot-plug strapped on
    assign hotPlugFwd = state_reg.hotPlug && !state_reg.reverseMode; // RULE10

    // Low half belongs to the ID and pointer bytes, read as zero here
    always_comb begin
        capUpper = '0;
        capUpper.version = exc_pkg::CAP_VERSION; // RULE15
        capUpper.intMsg = exc_pkg::INT_MSG_NUM; // RULE15
        capUpper.slotImpl = state_reg.reverseMode; // RULE3
        if (state_reg.reverseMode) begin
            capUpper.portType = exc_pkg::EXC_PT_CONV_TO_EXP; // RULE1 RULE2
        end else begin
            capUpper.portType = exc_pkg::EXC_PT_EXP_TO_CONV; // RULE1 RULE2
        end
    end

    // Reserved fields stay zero from the default
    always_comb begin
        devCap = '0;
        devCap.maxPayload = exc_pkg::MPS_SUPPORTED; // RULE14
        devCap.phantom = 2'h0; // RULE4
        devCap.extTag = 1'b1; // RULE5
        devCap.l0sLat = exc_pkg::L0S_ACCEPT; // RULE6 RULE7
        devCap.l1Lat = exc_pkg::L1_ACCEPT; // RULE8 RULE9
        devCap.attBtn = hotPlugFwd; // RULE10
        devCap.attInd = hotPlugFwd; // RULE11
        devCap.pwrInd = hotPlugFwd; // RULE11
        devCap.pwrValue = state_reg.pwrValue; // RULE12
        devCap.pwrScale = state_reg.pwrScale; // RULE13
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    assign reqHit = wbReq.cyc && wbReq.stb;

    // Straps taken on the first edge after release, not under reset
    always_comb begin
        state_next = state_reg;
        if (!state_reg.strapDone) begin
            state_next.strapDone = 1'b1;
            state_next.reverseMode = reverseStrap;
            state_next.hotPlug = hotPlugStrap;
        end
        // Message load; no clear exists, so nothing to race
        if (pwrMsg.valid) begin
            state_next.pwrValue = pwrMsg.value; // RULE12
            state_next.pwrScale = pwrMsg.scale; // RULE13
        end
        // Single-wait-state slave: ack rises on the edge that sees the request
        case (state_reg.busState)
            exc_pkg::EXC_ST_IDLE: begin
                state_next.rspAck = 1'b0;
                state_next.rspDat = '0;
                if (reqHit) begin
                    state_next.busState = exc_pkg::EXC_ST_ACK;
                    state_next.rspAck = 1'b1;
                    state_next.reqAdr = wbReq.adr;
                    // Everything is read-only; writes are acked and dropped
                    if (!wbReq.we) begin
                        if (wbReq.adr[7:2] == exc_pkg::OFF_CAP_UPPER[7:2]) begin
                            state_next.rspDat = capUpper;
                        end else if (wbReq.adr[7:2] == exc_pkg::OFF_DEV_CAP[7:2]) begin
                            state_next.rspDat = devCap;
                        end
                    end
                end
            end
            exc_pkg::EXC_ST_ACK: begin
                // Master releases on the ack edge; drop ack here
                state_next.busState = exc_pkg::EXC_ST_IDLE;
                state_next.rspAck = 1'b0;
                state_next.rspDat = '0;
            end
            default: begin
                state_next.busState = exc_pkg::EXC_ST_IDLE;
                state_next.rspAck = 1'b0;
                state_next.rspDat = '0;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_reg <= RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the register
    assign wbRsp = '{dat: state_reg.rspDat, ack: state_reg.rspAck};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic ackCap;
    logic ackDev;

    // Answers, read or write, from each of the two words
    assign ackCap = wbRsp.ack && (state_reg.reqAdr[7:2] == exc_pkg::OFF_CAP_UPPER[7:2]);
    assign ackDev = wbRsp.ack && (state_reg.reqAdr[7:2] == exc_pkg::OFF_DEV_CAP[7:2]);

    property p_type_legal;
        @(posedge clock) disable iff (!rstSyncN)
        ackCap && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_PORT_TYPE +: 4]
            inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    endproperty
    a_type_legal: assert property (p_type_legal) else $error("reserved port type"); // RULE1

    property p_type_mode;
        @(posedge clock) disable iff (!rstSyncN)
        ackCap && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_PORT_TYPE +: 4]
            == (state_reg.reverseMode ? 4'h8 : 4'h7);
    endproperty
    a_type_mode: assert property (p_type_mode) else $error("port type vs mode"); // RULE2

    property p_slot;
        @(posedge clock) disable iff (!rstSyncN)
        ackCap && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_SLOT] == state_reg.reverseMode;
    endproperty
    a_slot: assert property (p_slot) else $error("slot flag vs mode"); // RULE3

    property p_phantom;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_PHANTOM +: 2] == 2'h0;
    endproperty
    a_phantom: assert property (p_phantom) else $error("phantom not zero"); // RULE4

    property p_ext_tag;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_EXT_TAG];
    endproperty
    a_ext_tag: assert property (p_ext_tag) else $error("tag bit not set"); // RULE5

    property p_l0s;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_L0S +: 3] == 3'h0;
    endproperty
    a_l0s: assert property (p_l0s) else $error("l0s latency not zero"); // RULE6

    property p_l0s_code;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_L0S +: 3] != 3'h7;
    endproperty
    a_l0s_code: assert property (p_l0s_code) else $error("l0s code wrong"); // RULE7

    property p_l1;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_L1 +: 3] == 3'h0;
    endproperty
    a_l1: assert property (p_l1) else $error("l1 latency not zero"); // RULE8

    property p_l1_code;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_L1 +: 3] != 3'h7;
    endproperty
    a_l1_code: assert property (p_l1_code) else $error("l1 code wrong"); // RULE9

    property p_att_btn;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_ATT_BTN]
            == (state_reg.hotPlug && !state_reg.reverseMode);
    endproperty
    a_att_btn: assert property (p_att_btn) else $error("button flag wrong"); // RULE10

    property p_indicators;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[exc_pkg::POS_ATT_IND] == wbRsp.dat[exc_pkg::POS_PWR_IND]
            && wbRsp.dat[exc_pkg::POS_ATT_IND] == wbRsp.dat[exc_pkg::POS_ATT_BTN];
    endproperty
    a_indicators: assert property (p_indicators) else $error("indicator flags wrong"); // RULE11

    property p_pwr_value;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_PWR_VAL +: 8]
            == $past(state_reg.pwrValue) && wbRsp.dat[exc_pkg::POS_PWR_SCALE +: 2]
            == $past(state_reg.pwrScale);
    endproperty
    a_pwr_value: assert property (p_pwr_value) else $error("power value not loaded"); // RULE12

    property p_pwr_scale;
        @(posedge clock) disable iff (!rstSyncN)
        pwrMsg.valid |=> state_reg.pwrScale == $past(pwrMsg.scale)
            && state_reg.pwrValue == $past(pwrMsg.value);
    endproperty
    a_pwr_scale: assert property (p_pwr_scale) else $error("power scale not loaded"); // RULE13

    property p_pwr_reset;
        @(posedge clock) disable iff (!rstSyncN)
        $rose(state_reg.strapDone) |-> state_reg.pwrValue == 8'h00 && state_reg.pwrScale == 2'h0;
    endproperty
    a_pwr_reset: assert property (p_pwr_reset) else $error("power field reset wrong"); // RULE12

    property p_payload;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_MPS +: 3] == 3'h1;
    endproperty
    a_payload: assert property (p_payload) else $error("payload code wrong"); // RULE14

    property p_fixed_upper;
        @(posedge clock) disable iff (!rstSyncN)
        ackCap && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_VERSION +: 4] == 4'h1
            && wbRsp.dat[31:exc_pkg::POS_INT_MSG] == 7'h00 && wbRsp.dat[15:0] == 16'h0000;
    endproperty
    a_fixed_upper: assert property (p_fixed_upper) else $error("version or reserved wrong"); // RULE15

    property p_dev_rsvd;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev |-> wbRsp.dat[31:exc_pkg::POS_DEV_RSVD_HI] == 4'h0
            && wbRsp.dat[exc_pkg::POS_DEV_RSVD_MID +: 3] == 3'h0;
    endproperty
    a_dev_rsvd: assert property (p_dev_rsvd) else $error("reserved bits set"); // RULE15

    property p_write_ignored;
        @(posedge clock) disable iff (!rstSyncN)
        state_reg.busState == exc_pkg::EXC_ST_IDLE && reqHit && wbReq.we
            |=> wbRsp.ack && wbRsp.dat == 32'h0000_0000 ##1 !wbRsp.ack;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write not dropped"); // RULE15

    property p_strap_capture;
        @(posedge clock) disable iff (!rstSyncN)
        $rose(state_reg.strapDone) |-> state_reg.reverseMode == $past(reverseStrap)
            && state_reg.hotPlug == $past(hotPlugStrap);
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap missed"); // RULE10

    property p_strap_hold;
        @(posedge clock) disable iff (!rstSyncN)
        state_reg.strapDone |=> $stable(state_reg.reverseMode) && $stable(state_reg.hotPlug);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap copy moved"); // RULE2

    property p_slot_type;
        @(posedge clock) disable iff (!rstSyncN)
        ackCap && $past(!wbReq.we) |-> wbRsp.dat[exc_pkg::POS_SLOT] == wbRsp.dat[23];
    endproperty
    a_slot_type: assert property (p_slot_type) else $error("slot vs type"); // RULE3

    property p_rev_no_ind;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && state_reg.reverseMode |-> wbRsp.dat[exc_pkg::POS_ATT_BTN +: 3] == 3'h0;
    endproperty
    a_rev_no_ind: assert property (p_rev_no_ind) else $error("reverse flags set"); // RULE10

    property p_nohp_no_ind;
        @(posedge clock) disable iff (!rstSyncN)
        ackDev && !state_reg.hotPlug |-> wbRsp.dat[exc_pkg::POS_ATT_BTN +: 3] == 3'h0;
    endproperty
    a_nohp_no_ind: assert property (p_nohp_no_ind) else $error("no hot-plug flags"); // RULE11

    property p_dat_idle;
        @(posedge clock) disable iff (!rstSyncN)
        !wbRsp.ack |-> wbRsp.dat == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack"); // RULE15

    // Captured limit must survive every cycle without a message
    property p_pwr_hold;
        @(posedge clock) disable iff (!rstSyncN)
        !pwrMsg.valid |=> $stable(state_reg.pwrValue) && $stable(state_reg.pwrScale);
    endproperty
    a_pwr_hold: assert property (p_pwr_hold) else $error("power limit moved"); // RULE13

endmodule // exc_capability_fields

// File: rtl/exc_pkg.sv
package exc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADR_W = 8;
    localparam logic [7:0] OFF_CAP_UPPER = 8'hb0;
    localparam logic [7:0] OFF_DEV_CAP = 8'hb4;

    // ----------------------------------------
    // Field positions, capability upper word
    // ----------------------------------------
    localparam int POS_VERSION = 16;
    localparam int POS_PORT_TYPE = 20;
    localparam int POS_SLOT = 24;
    localparam int POS_INT_MSG = 25;
    localparam int POS_CAP_RSVD = 30;

    // ----------------------------------------
    // Field positions, device capability word
    // ----------------------------------------
    localparam int POS_MPS = 0;
    localparam int POS_PHANTOM = 3;
    localparam int POS_EXT_TAG = 5;
    localparam int POS_L0S = 6;
    localparam int POS_L1 = 9;
    localparam int POS_ATT_BTN = 12;
    localparam int POS_ATT_IND = 13;
    localparam int POS_PWR_IND = 14;
    localparam int POS_DEV_RSVD_MID = 15;
    localparam int POS_PWR_VAL = 18;
    localparam int POS_PWR_SCALE = 26;
    localparam int POS_DEV_RSVD_HI = 28;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    typedef enum logic [3:0] {
        EXC_PT_ENDPOINT = 4'h0,
        EXC_PT_LEGACY_EP = 4'h1,
        EXC_PT_ROOT_PORT = 4'h4,
        EXC_PT_SW_UP = 4'h5,
        EXC_PT_SW_DOWN = 4'h6,
        EXC_PT_EXP_TO_CONV = 4'h7,
        EXC_PT_CONV_TO_EXP = 4'h8
    } exc_port_type_e;

    typedef enum logic [2:0] {
        EXC_MPS_128 = 3'h0,
        EXC_MPS_256 = 3'h1,
        EXC_MPS_512 = 3'h2,
        EXC_MPS_1024 = 3'h3,
        EXC_MPS_2048 = 3'h4,
        EXC_MPS_4096 = 3'h5
    } exc_payload_e;

    // Doubling ranges from 64 ns
    typedef enum logic [2:0] {
        EXC_L0S_LT_64NS = 3'h0, EXC_L0S_64_128NS = 3'h1, EXC_L0S_128_256NS = 3'h2,
        EXC_L0S_256_512NS = 3'h3, EXC_L0S_512NS_1US = 3'h4, EXC_L0S_1_2US = 3'h5,
        EXC_L0S_2_4US = 3'h6, EXC_L0S_GT_4US = 3'h7
    } exc_l0s_lat_e;

    // Doubling ranges from 1 us
    typedef enum logic [2:0] {
        EXC_L1_LT_1US = 3'h0, EXC_L1_1_2US = 3'h1, EXC_L1_2_4US = 3'h2,
        EXC_L1_4_8US = 3'h3, EXC_L1_8_16US = 3'h4, EXC_L1_16_32US = 3'h5,
        EXC_L1_32_64US = 3'h6, EXC_L1_GT_64US = 3'h7
    } exc_l1_lat_e;

    typedef enum logic [1:0] {
        EXC_ST_IDLE = 2'b01,
        EXC_ST_ACK = 2'b10
    } exc_bus_state_e;

    // ----------------------------------------
    // Fixed values and reset values
    // ----------------------------------------
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [4:0] INT_MSG_NUM = 5'h00;
    localparam exc_payload_e MPS_SUPPORTED = EXC_MPS_256;
    localparam exc_l0s_lat_e L0S_ACCEPT = EXC_L0S_LT_64NS;
    localparam exc_l1_lat_e L1_ACCEPT = EXC_L1_LT_1US;
    localparam logic [7:0] RST_PWR_VALUE = 8'h00;
    localparam logic [1:0] RST_PWR_SCALE = 2'h0;
    localparam logic [31:0] RST_RSP_DAT = 32'h0000_0000;
    localparam logic [7:0] RST_ADR = 8'h00;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } exc_wb_req_s;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } exc_wb_rsp_s;

    typedef struct packed {
        logic valid;
        logic [1:0] scale;
        logic [7:0] value;
    } exc_pwr_msg_s;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [4:0] intMsg;
        logic slotImpl;
        exc_port_type_e portType;
        logic [3:0] version;
        logic [15:0] lowHalf;
    } exc_cap_upper_s;

    typedef struct packed {
        logic [3:0] rsvdHi;
        logic [1:0] pwrScale;
        logic [7:0] pwrValue;
        logic [2:0] rsvdMid;
        logic pwrInd;
        logic attInd;
        logic attBtn;
        exc_l1_lat_e l1Lat;
        exc_l0s_lat_e l0sLat;
        logic extTag;
        logic [1:0] phantom;
        exc_payload_e maxPayload;
    } exc_dev_cap_s;

endpackage

// File: rtl/exc_reset_sync.sv
`timescale 1ns/100ps

// Two-stage release of an asynchronous active-low reset
module exc_reset_sync (
    input wire logic clock,
    input wire logic reset_n,
    output logic rstSyncN
);

    logic stageOne;

    // ----------------------------------------
    // Assert at once, release on the clock
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stageOne <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            stageOne <= 1'b1;
            rstSyncN <= stageOne; // Only reader of the first stage
        end
    end

endmodule // exc_reset_sync

// File: verification/exc_cfg_master.sv
`timescale 1ns/100ps

// ----------------------------------------
// Configuration software seen as a Wishbone master
// ----------------------------------------
module exc_cfg_master (
    input wire logic clock,
    output exc_pkg::exc_wb_req_s wbReq,
    input wire exc_pkg::exc_wb_rsp_s wbRsp
);

    // Idle bus until the first access
    initial begin
        wbReq = '0;
    end

    // One classic cycle; waits for the answer with no assumed latency
    task automatic transfer(
        input logic we,
        input logic [7:0] adr,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        @(posedge clock);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        do begin
            @(posedge clock);
        end while (wbRsp.ack !== 1'b1);
        // Released lines carry junk so stale values never look valid
        wbReq <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: ~sel, dat: ~dat};
        @(posedge clock);
    endtask

endmodule // exc_cfg_master

// File: verification/testbench.sv
`timescale 1ns/100ps

module testbench;

    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    logic clock = 1'b0;
    logic reset_n = 1'b1;
    logic reverseStrap = 1'b0;
    logic hotPlugStrap = 1'b0;
    exc_pkg::exc_pwr_msg_s pwrMsg = '0;
    exc_pkg::exc_wb_req_s wbReq;
    exc_pkg::exc_wb_rsp_s wbRsp;
    logic [31:0] expQ[$];
    logic [31:0] expHead;
    logic [7:0] pwrVal = 8'h00;
    logic [1:0] pwrScl = 2'h0;
    int miscompares = 0;
    int samplesChecked = 0;

    // 125 MHz clock
    always #4 clock = ~clock;

    exc_capability_fields i_exc_capability_fields (
        .clock(clock),
        .reset_n(reset_n),
        .wbReq(wbReq),
        .wbRsp(wbRsp),
        .reverseStrap(reverseStrap),
        .hotPlugStrap(hotPlugStrap),
        .pwrMsg(pwrMsg)
    );

    exc_cfg_master i_exc_cfg_master (
        .clock(clock),
        .wbReq(wbReq),
        .wbRsp(wbRsp)
    );

    // ----------------------------------------
    // Expected words, from the field layout
    // ----------------------------------------
    function automatic logic [31:0] expWord(input logic [7:0] adr, input logic rev,
                                            input logic hp);
        logic ind;
        ind = hp & ~rev;
        case (adr[7:2])
            6'h2c: return {2'b00, 5'h00, rev, rev ? 4'h8 : 4'h7, 4'h1, 16'h0000};
            6'h2d: return {4'h0, pwrScl, pwrVal, 3'h0, {3{ind}}, 3'h0, 3'h0, 1'b1,
                           2'b00, 3'h1};
            default: return 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------
    // Result watcher: every ack takes the oldest note
    // ----------------------------------------
    always @(posedge clock) begin
        if (wbRsp.ack === 1'b1) begin
            samplesChecked++;
            expHead = (expQ.size() != 0) ? expQ.pop_front() : 32'hdead_beef;
            if (wbRsp.dat !== expHead) begin
                miscompares++;
                $display("MISMATCH t=%0t exp=%h got=%h", $time, expHead, wbRsp.dat);
            end
        end else if (wbRsp.dat !== 32'h0000_0000) begin
            // Data must not linger outside the answer cycle
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h0, wbRsp.dat);
        end
    end

    // ----------------------------------------
    // Driver tasks
    // ----------------------------------------
    task automatic access(input logic we, input logic [7:0] adr);
        expQ.push_back(we ? 32'h0000_0000 : expWord(adr, reverseStrap, hotPlugStrap));
        i_exc_cfg_master.transfer(we, adr, $urandom, 4'($urandom));
    endtask

    // Straps settle before release, since they are sampled only once
    // Asserted at once, so outputs are defined before the first edge
    task automatic do_reset(input logic rev, input logic hp);
        reset_n <= 1'b0;
        reverseStrap <= rev;
        hotPlugStrap <= hp;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        pwrVal = 8'h00;
        pwrScl = 2'h0;
    endtask

    // Back-to-back messages; the last one is the one that sticks
    task automatic send_pwr(input int n);
        repeat (n) begin
            @(posedge clock);
            pwrVal = 8'($urandom);
            pwrScl = 2'($urandom);
            pwrMsg <= {1'b1, pwrScl, pwrVal};
        end
        @(posedge clock);
        pwrMsg <= {1'b0, ~pwrScl, ~pwrVal};
    endtask

    task automatic run_mode(input logic rev, input logic hp);
        do_reset(rev, hp);
        access(1'b0, 8'hb4);
        access(1'b0, 8'hb0);
        access(1'b0, 8'hb6);
        access(1'b1, 8'hb4);
        access(1'b1, 8'hb0);
        access(1'b0, 8'hb0);
        access(1'b0, 8'hb8);
        send_pwr(2);
        access(1'b0, 8'hb4);
        send_pwr(1);
        access(1'b1, 8'hb5);
        access(1'b0, 8'hb7);
        repeat (3) @(posedge clock);
        if (expQ.size() != 0) begin
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h0, expQ.size());
            expQ.delete();
        end
        $display("TEST reverse=%0d hotplug=%0d done", rev, hp);
    endtask

    // ----------------------------------------
    // Verdict
    // ----------------------------------------
    task automatic end_sim;
        $display("COUNTS checked=%0d mismatches=%0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: four modes take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h1, 32'h0);
        end_sim();
    end

    // Every strap combination, each behind a fresh reset
    initial begin
        void'($urandom(32'h0186));
        for (int m = 0; m < 4; m++) begin
            run_mode(m[1], m[0]);
        end
        end_sim();
    end

endmodule // testbench
